// ==== verilog/dbs_pkg.sv ====
package dbs_pkg;

   // Channel count and pulse-width steps
   localparam int                NUM_CH         = 2;
   localparam int                PERIOD_CYC     = 256;      // Switching period in mclk cycles
   localparam logic [7:0]        PERIOD_LAST    = 8'hFF;
   localparam logic [3:0]        PULSES_PER_STEP = 4'hF;   // 16 pulses per step, count 0..15
   localparam logic [3:0]        WIDTH_STEPS    = 4'h8;     // Eighths of period, 1..8
   localparam logic [2:0]        EIGHTH_SHIFT   = 3'h5;     // 256/8 = 32 = 1 << 5

   // Soft-start reference: 16-bit code, full scale = final level
   localparam logic [15:0]       SS_FINAL       = 16'hFFFF;
   localparam logic [15:0]       SS_STEP        = 16'h0001;
   localparam int                SS_DIV_CYC     = 4;        // Mclk cycles per reference step
   localparam logic [3:0]        SS_DIV_LAST    = 4'h3;

   // Oscillator period slew for gradual frequency moves
   localparam int                OSC_SLEW_CYC   = 16;       // Cycles between period updates
   localparam logic [4:0]        OSC_SLEW_LAST  = 5'h0F;
   localparam logic [7:0]        OSC_RESET_PER  = 8'hFF;

   // Channel phases
   typedef enum logic [2:0] {
      DBS_OFF,
      DBS_ASYNC,
      DBS_PREBIAS,
      DBS_RUN,
      DBS_SHUT
   } dbs_state_t;

   // Monitored comparator levels
   typedef struct packed {
      logic bias_ok;
      logic bias_fall;
      logic [NUM_CH-1:0] en_rise;
      logic [NUM_CH-1:0] en_fall;
   } dbs_mon_t;

   // Fault indications
   typedef struct packed {
      logic overvoltage_guard;
      logic overcurrent_guard;
      logic over_temp;
   } dbs_fault_t;

endpackage : dbs_pkg

// ==== verilog/dbs_osc.sv ====
`timescale 1ns/1ns
// Switching oscillator with gradual period slew toward the target
module dbs_osc (
   // Clock and reset
   input  wire logic                 mclk_i,
   input  wire logic                 sys_rst_i,
   // Period targets
   input  wire logic [7:0]           free_period_i,
   input  wire logic [7:0]           ext_period_i,
   input  wire logic                 ext_clk_present_i,
   // Oscillator outputs
   output logic                      period_tick_o,
   output logic [7:0]                phase_o,
   output logic [7:0]                period_o
);
   import dbs_pkg::*;

   logic [7:0] phase;
   logic [7:0] period;
   logic [4:0] slew;
   logic [7:0] next_phase;
   logic [7:0] next_period;
   logic [4:0] next_slew;
   logic [7:0] target;

   // Step one count per slew interval so the frequency never jumps
   always_comb begin
      target      = ext_clk_present_i ? ext_period_i : free_period_i;
      next_slew   = (slew == OSC_SLEW_LAST) ? 5'h00 : slew + 5'h01;
      next_period = period;
      if (slew == OSC_SLEW_LAST) begin
         if (period < target) begin
            next_period = period + 8'h01;
         end else if (period > target) begin
            next_period = period - 8'h01;
         end
      end
      next_phase = (phase >= period) ? 8'h00 : phase + 8'h01;
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         phase  <= 8'h00;
         period <= OSC_RESET_PER;
         slew   <= 5'h00;
      end else begin
         phase  <= next_phase;
         period <= next_period;
         slew   <= next_slew;
      end
   end

   assign period_tick_o = (phase >= period);
   assign phase_o       = phase;
   assign period_o      = period;

endmodule : dbs_osc

// ==== verilog/dbs_seq.sv ====
`timescale 1ns/1ns
// Functional notes
// - Drivers off while bias or enable low
// - Supply-valid only when all inputs valid
// - Channel on above enable rise threshold
// - Low-side off until first high-side pulse
// - First low-side pulses one eighth period
// - Add an eighth every 16 pulses
// - Soft-start waits for supply-valid
// - Reference ramps from zero, fixed slope
// - Current and voltage guards active during soft-start
// - Bias fall flags undervoltage, all off
// - Any fault stops switching
// - Each enable shuts its own channel
// - Frequency moves gradually to new target
module dbs_seq (
   // Clock and reset
   input  wire logic                       mclk_i,
   input  wire logic                       sys_rst_i,
   // Comparator and fault inputs
   input  dbs_pkg::dbs_mon_t               mon_i,
   input  dbs_pkg::dbs_fault_t             fault_i,
   // Per-channel high-side demand from the modulator
   input  wire logic [1:0]                 hs_demand_i,
   // Frequency setting
   input  wire logic [7:0]                 free_period_i,
   input  wire logic [7:0]                 ext_period_i,
   input  wire logic                       ext_clk_present_i,
   // Driver outputs
   output logic [1:0]                      high_side_switch_o,
   output logic [1:0]                      low_side_switch_o,
   // Status
   output logic                            supply_valid_o,
   output logic                            uvlo_event_o,
   output logic [1:0]                      ss_done_o,
   output logic [31:0]                     ss_ref_o,
   output logic [5:0]                      ch_state_o,
   output logic [7:0]                      period_o
);
   import dbs_pkg::*;

   logic       tick;
   logic [7:0] phase;
   logic       bias_valid;
   logic       next_bias_valid;
   logic       supply_valid;
   logic       next_supply_valid;
   logic       uvlo_event;
   logic       next_uvlo_event;
   logic       fault_any;
   logic [1:0] en_on;
   logic [1:0] next_en_on;

   // Oscillator that sets the switching period
   dbs_osc u_osc (
      .mclk_i            (mclk_i),
      .sys_rst_i         (sys_rst_i),
      .free_period_i     (free_period_i),
      .ext_period_i      (ext_period_i),
      .ext_clk_present_i (ext_clk_present_i),
      .period_tick_o     (tick),
      .phase_o           (phase),
      .period_o          (period_o)
   );

   // Low-side width in eighths of the running period
   function automatic logic [8:0] ls_width(input logic [3:0] steps, input logic [7:0] per);
      logic [11:0] w;
      w = (12'(per) + 12'h001) * 12'(steps);
      return w[11:3];
   endfunction : ls_width

   // Hysteresis: rise threshold sets, lower fall threshold clears
   always_comb begin
      next_bias_valid = bias_valid;
      if (mon_i.bias_fall) begin
         next_bias_valid = 1'b0;
      end else if (mon_i.bias_ok) begin
         next_bias_valid = 1'b1;
      end
      for (int i = 0; i < NUM_CH; i++) begin
         next_en_on[i] = en_on[i];
         if (!mon_i.en_fall[i]) begin
            next_en_on[i] = 1'b0;
         end else if (mon_i.en_rise[i]) begin
            next_en_on[i] = 1'b1;
         end
      end
      // Valid only with bias and every enable good
      next_supply_valid = next_bias_valid && (&next_en_on);
      // Sticky until the bias is good again; set wins over clear
      next_uvlo_event = mon_i.bias_fall ? 1'b1 : (mon_i.bias_ok ? 1'b0 : uvlo_event);
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         bias_valid   <= 1'b0;
         en_on        <= 2'h0;
         supply_valid <= 1'b0;
         uvlo_event   <= 1'b0;
      end else begin
         bias_valid   <= next_bias_valid;
         en_on        <= next_en_on;
         supply_valid <= next_supply_valid;
         uvlo_event   <= next_uvlo_event;
      end
   end

   // Guards stay live in every phase, soft-start included
   assign fault_any = fault_i.overvoltage_guard | fault_i.overcurrent_guard
                      | fault_i.over_temp;

   assign supply_valid_o = supply_valid;
   assign uvlo_event_o   = uvlo_event;

   // One sequencer per channel
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         dbs_state_t  st;
         dbs_state_t  next_st;
         logic [3:0]  pcnt;
         logic [3:0]  next_pcnt;
         logic [3:0]  steps;
         logic [3:0]  next_steps;
         logic [15:0] ssref;
         logic [15:0] next_ssref;
         logic [3:0]  ssdiv;
         logic [3:0]  next_ssdiv;
         logic        hs;
         logic        next_hs;
         logic        ls;
         logic        next_ls;
         logic        ch_ok;

         // Staying on needs bias, own enable and no fault; the other enable is
         // ignored so one channel can be dropped without disturbing its partner
         assign ch_ok = bias_valid && en_on[g] && !fault_any;

         always_comb begin
            next_st    = st;
            next_pcnt  = pcnt;
            next_steps = steps;
            next_ssref = ssref;
            next_ssdiv = ssdiv;
            next_hs    = 1'b0;
            next_ls    = 1'b0;
            case (st)
               DBS_OFF: begin
                  next_pcnt  = 4'h0;
                  next_steps = 4'h1;
                  next_ssref = 16'h0000;
                  if (ch_ok && supply_valid) begin
                     next_st = DBS_ASYNC;
                  end
               end
               DBS_ASYNC: begin
                  // Diode-mode start: only high-side may fire
                  next_hs = hs_demand_i[g];
                  if (hs_demand_i[g]) begin
                     next_st = DBS_PREBIAS;
                  end
               end
               DBS_PREBIAS: begin
                  next_hs = hs_demand_i[g];
                  next_ls = !hs_demand_i[g] &&
                            ({1'b0, phase} < ls_width(steps, period_o));
                  if (tick) begin
                     next_pcnt = pcnt + 4'h1;
                     if (pcnt == PULSES_PER_STEP) begin
                        if (steps == WIDTH_STEPS) begin
                           next_st = DBS_RUN;
                        end else begin
                           next_steps = steps + 4'h1;
                        end
                     end
                  end
               end
               DBS_RUN: begin
                  next_hs = hs_demand_i[g];
                  next_ls = !hs_demand_i[g];
               end
               DBS_SHUT: begin
                  next_st = DBS_OFF;
               end
               default: begin
                  next_st = DBS_OFF;
               end
            endcase
            // Reference ramp runs from the first start phase, fixed slope
            if (st != DBS_OFF && st != DBS_SHUT) begin
               next_ssdiv = (ssdiv == SS_DIV_LAST) ? 4'h0 : ssdiv + 4'h1;
               if (ssdiv == SS_DIV_LAST && ssref != SS_FINAL) begin
                  next_ssref = ssref + SS_STEP;
               end
            end
            // Loss of bias, enable or a fault drops the channel at once
            if (st != DBS_OFF && !ch_ok) begin
               next_st    = DBS_SHUT;
               next_hs    = 1'b0;
               next_ls    = 1'b0;
               next_pcnt  = 4'h0;
               next_steps = 4'h1;
               next_ssref = 16'h0000;
            end
         end

         always_ff @(posedge mclk_i) begin
            if (sys_rst_i) begin
               st    <= DBS_OFF;
               pcnt  <= 4'h0;
               steps <= 4'h1;
               ssref <= 16'h0000;
               ssdiv <= 4'h0;
               hs    <= 1'b0;
               ls    <= 1'b0;
            end else begin
               st    <= next_st;
               pcnt  <= next_pcnt;
               steps <= next_steps;
               ssref <= next_ssref;
               ssdiv <= next_ssdiv;
               hs    <= next_hs;
               ls    <= next_ls;
            end
         end

         assign high_side_switch_o[g]     = hs;
         assign low_side_switch_o[g]      = ls;
         assign ss_ref_o[16*g +: 16]      = ssref;
         assign ss_done_o[g]              = (ssref == SS_FINAL);
         assign ch_state_o[3*g +: 3]      = st;
      end
   endgenerate

endmodule : dbs_seq

// ==== test/dbs_rails.sv ====
`timescale 1ns/1ns
// Rails and system enable logic seen by the sequencer
module dbs_rails (
   // Plain levels from the bench
   input  wire logic          bias_on_i,
   input  wire logic [1:0]    en_on_i,
   input  wire logic [2:0]    fault_on_i,
   // Comparator and fault levels
   output dbs_pkg::dbs_mon_t   mon_o,
   output dbs_pkg::dbs_fault_t fault_o
);
   import dbs_pkg::*;
   // Bias is above its start level or below its stop level, never both
   assign mon_o.bias_ok   = bias_on_i;
   assign mon_o.bias_fall = !bias_on_i;
   // Each channel enable is moved on its own, no hysteresis gap modelled
   assign mon_o.en_rise   = en_on_i;
   assign mon_o.en_fall   = en_on_i;
   assign fault_o         = fault_on_i;
endmodule : dbs_rails

// ==== test/dbs_seq_chk.sv ====
`timescale 1ns/1ns
// Port-level checker for the sequencer
module dbs_seq_chk (
   input  wire logic          mclk_i,
   input  wire logic          sys_rst_i,
   input  dbs_pkg::dbs_mon_t   mon_i,
   input  dbs_pkg::dbs_fault_t fault_i,
   input  wire logic [1:0]    high_side_switch_o,
   input  wire logic [1:0]    low_side_switch_o,
   input  wire logic          supply_valid_o,
   input  wire logic          uvlo_event_o,
   input  wire logic [31:0]   ss_ref_o,
   input  wire logic [5:0]    ch_state_o,
   input  wire logic [7:0]    period_o
);
   import dbs_pkg::*;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   // Three cycles cover the input latch and the driver register
   sequence s_bias_low; mon_i.bias_fall [*3]; endsequence
   sequence s_ref_start; ch_state_o[2:0] == 3'h0 ##1 ch_state_o[2:0] == 3'h1; endsequence
   property p_bias_off; s_bias_low |-> (high_side_switch_o | low_side_switch_o) == 2'h0; endproperty
   property p_valid; supply_valid_o |-> $past(!mon_i.bias_fall) && $past(&mon_i.en_fall);
   endproperty
   property p_async; (ch_state_o[2:0] != 3'h1 || !low_side_switch_o[0])
      && (ch_state_o[5:3] != 3'h1 || !low_side_switch_o[1]); endproperty
   // Start leaves OFF only on a valid supply, and the ramp begins at zero
   property p_ss_start; s_ref_start |-> $past(supply_valid_o) && ss_ref_o[15:0] == 16'h0000;
   endproperty
   // One code per step, then three quiet cycles, unless shut down
   property p_slope; $changed(ss_ref_o[15:0]) && ss_ref_o[15:0] != 16'h0000
      |-> ss_ref_o[15:0] == $past(ss_ref_o[15:0]) + 16'h0001
      ##1 ($stable(ss_ref_o[15:0]) || ss_ref_o[15:0] == 16'h0000) [*3]; endproperty
   property p_uvlo; s_bias_low |-> uvlo_event_o; endproperty
   property p_fault; (|fault_i) [*3] |-> (high_side_switch_o | low_side_switch_o) == 2'h0;
   endproperty
   property p_ch_off; (!mon_i.en_fall[0]) [*3] |-> !high_side_switch_o[0] && !low_side_switch_o[0];
   endproperty
   property p_slew; $changed(period_o)
      |-> period_o == $past(period_o) + 8'h01 || period_o == $past(period_o) - 8'h01; endproperty
   a_bias_off: assert property (p_bias_off) else $error("driver on with bias low");
   a_valid: assert property (p_valid) else $error("supply valid without inputs");
   a_async: assert property (p_async) else $error("low side on before first pulse");
   a_ss_start: assert property (p_ss_start) else $error("ramp before supply valid");
   a_slope: assert property (p_slope) else $error("reference slope wrong");
   a_uvlo: assert property (p_uvlo) else $error("no undervoltage event");
   a_fault: assert property (p_fault) else $error("switching during fault");
   a_ch_off: assert property (p_ch_off) else $error("channel on while disabled");
   a_slew: assert property (p_slew) else $error("period jumped");
endmodule : dbs_seq_chk
bind dbs_seq dbs_seq_chk u_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .mon_i(mon_i),
   .fault_i(fault_i), .high_side_switch_o(high_side_switch_o),
   .low_side_switch_o(low_side_switch_o), .supply_valid_o(supply_valid_o),
   .uvlo_event_o(uvlo_event_o), .ss_ref_o(ss_ref_o), .ch_state_o(ch_state_o),
   .period_o(period_o));

// ==== test/dbs_seq_tb_top.sv ====
`timescale 1ns/1ns
module dbs_seq_tb_top;
   import dbs_pkg::*;
   // Row: bias, enables, faults, then supply valid, uvlo, drivers on (high or low side)
   typedef struct packed {logic b; logic [1:0] e; logic [2:0] f;
      logic sv; logic uv; logic [1:0] hs;} dbs_row_t;
   dbs_row_t   rows [10] = '{10'h38B, 10'h302, 10'h38B, 10'h3C8, 10'h3A8,
                             10'h398, 10'h38B, 10'h184, 10'h38B, 10'h200};
   logic       mclk_i, sys_rst_i, bias_on, ext_on;
   logic [1:0] en_on, hs_dem, hs, ls, done;
   logic [2:0] fault_on;
   logic [7:0] free_per, ext_per, per;
   logic       sv, uv;
   logic [31:0] ref_v;
   logic [5:0] st;
   dbs_mon_t   mon;
   dbs_fault_t fault;
   int         n_errors, n_compared;
   dbs_rails u_rails (.bias_on_i(bias_on), .en_on_i(en_on), .fault_on_i(fault_on),
      .mon_o(mon), .fault_o(fault));
   dbs_seq dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .mon_i(mon), .fault_i(fault),
      .hs_demand_i(hs_dem), .free_period_i(free_per), .ext_period_i(ext_per),
      .ext_clk_present_i(ext_on), .high_side_switch_o(hs), .low_side_switch_o(ls),
      .supply_valid_o(sv), .uvlo_event_o(uv), .ss_done_o(done), .ss_ref_o(ref_v),
      .ch_state_o(st), .period_o(per));
   // Free-running 250 MHz clock
   initial begin
      mclk_i = 1'h0;
      forever #2 mclk_i = ~mclk_i;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task print_verdict;
      $display("compared %0d, errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : print_verdict
   // Widths are counted per low-side run, so a partial first period is harmless
   task prebias;
      int w, k, w1, c [0:33];
      c = '{default: 0};
      w = 0;
      k = 0;
      w1 = 0;
      @(negedge mclk_i) hs_dem = 2'h3;
      @(negedge mclk_i) hs_dem = 2'h0;
      repeat (4300) begin
         @(negedge mclk_i);
         if (ls[0] === 1'h1) w++;
         else if (w > 0) begin
            if (k == 1) w1 = w;
            if (w < 34) c[w]++;
            k++;
            w = 0;
         end
      end
      chk(w1, 4);
      for (int s = 2; s < 8; s++) chk(c[4 * s], 16);
      chk(st[2:0], 3'h3);
      $display("prebias done");
   endtask : prebias
   // Hang guard sized well above the planned run
   initial begin
      #400000;
      n_errors++;
      print_verdict;
   end
   initial begin
      {sys_rst_i, bias_on, en_on, fault_on, hs_dem, ext_on} = 10'h200;
      free_per = 8'h1F;
      ext_per = 8'h27;
      n_errors = 0;
      n_compared = 0;
      repeat (5) @(negedge mclk_i);
      sys_rst_i = 1'h0;
      hs_dem = 2'h3;
      foreach (rows[i]) begin
         {bias_on, en_on, fault_on} = {rows[i].b, rows[i].e, rows[i].f};
         repeat (16) @(negedge mclk_i);
         chk(sv, rows[i].sv);
         chk(uv, rows[i].uv);
         chk(hs | ls, rows[i].hs);
      end
      $display("table done");
      // Mid-run reset, then hold both channels waiting for a first pulse
      sys_rst_i = 1'h1;
      hs_dem = 2'h0;
      en_on = 2'h3;
      repeat (2) @(negedge mclk_i);
      chk(st, 6'h00);
      sys_rst_i = 1'h0;
      for (int t = 0; t < 5000 && per !== 8'h1F; t++) @(negedge mclk_i);
      chk(per, 8'h1F);
      chk(st, 6'h09);
      chk(ls, 2'h0);
      w_ref: begin
         logic [15:0] r0;
         r0 = ref_v[15:0];
         repeat (400) @(negedge mclk_i);
         chk(ref_v[15:0] - r0, 16'h0064);
         chk(done, 2'h0);
      end
      $display("restart done");
      ext_on = 1'h1;
      repeat (40) @(negedge mclk_i);
      chk(per > 8'h1F && per < 8'h27, 1'h1);
      repeat (200) @(negedge mclk_i);
      chk(per, 8'h27);
      ext_on = 1'h0;
      repeat (200) @(negedge mclk_i);
      chk(per, 8'h1F);
      $display("frequency done");
      prebias;
      en_on = 2'h0;
      repeat (10) @(negedge mclk_i);
      en_on = 2'h3;
      repeat (10) @(negedge mclk_i);
      prebias;
      print_verdict;
   end
endmodule : dbs_seq_tb_top
